// ### sacc_defs.svh
// register offsets, field positions, reset values and timing counts of the conversion control
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SACC_OFF_CTRL 8'h00
`define SACC_OFF_CFG 8'h04
`define SACC_OFF_RES_HI 8'h08
`define SACC_OFF_RES_LO 8'h0C
`define SACC_OFF_IRQ_EN 8'h10

// ************************************************************
// control register fields
// ************************************************************
`define SACC_CTRL_EN_BIT 7
`define SACC_CTRL_DTRACK_BIT 6
`define SACC_CTRL_DONE_BIT 5
`define SACC_CTRL_BUSY_BIT 4
`define SACC_CTRL_MODE_MSB 2
`define SACC_CTRL_MODE_LSB 0
`define SACC_CTRL_RST 8'h00

// ************************************************************
// configuration register fields
// ************************************************************
`define SACC_CFG_DIV_MSB 7
`define SACC_CFG_DIV_LSB 3
`define SACC_CFG_LJST_BIT 2
`define SACC_CFG_B8_BIT 1
`define SACC_CFG_GAIN_BIT 0
`define SACC_CFG_RST 8'hF9

// ************************************************************
// conversion delay in conversion-clock ticks, code bit indices and AXI response codes
// ************************************************************
`define SACC_DELAY_TICKS 2'h3
`define SACC_CODE_MSB_IDX 4'h9
`define SACC_LAST_IDX_10B 4'h0
`define SACC_LAST_IDX_8B 4'h2
`define SACC_AXI_OKAY 2'h0
`define SACC_AXI_SLVERR 2'h2

`endif

// ### sacc_pkg.sv
// types shared by the conversion control block
package sacc_pkg;

   // start-of-conversion source encodings of the start_mode_select field
   typedef enum logic [2:0] {
      SACC_MODE_SW = 3'h0,
      SACC_MODE_T0 = 3'h1,
      SACC_MODE_T2 = 3'h2,
      SACC_MODE_T1 = 3'h3,
      SACC_MODE_EXT = 3'h4,
      SACC_MODE_T3 = 3'h5
   } sacc_mode_t;

   // conversion sequencer states
   typedef enum logic [1:0] {
      SACC_ST_IDLE,
      SACC_ST_DELAY,
      SACC_ST_CONV
   } sacc_state_t;

   // overflow pulses and width modes of the on-chip timers
   typedef struct packed {
      logic t0_ovf;
      logic t1_ovf;
      logic t2_lo_ovf;
      logic t2_hi_ovf;
      logic t2_16bit;
      logic t3_lo_ovf;
      logic t3_hi_ovf;
      logic t3_16bit;
   } sacc_trig_t;

   // high and low result bytes
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } sacc_result_t;

endpackage

// ### sacc_top.sv
// conversion control of a 10-bit successive-approximation converter, with AXI4-Lite registers
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "sacc_defs.svh"

// Overview of operation
// - converter runs only while converter_enable is 1; otherwise shut down.
// - each result is an unsigned code of 10 bits, or 8 in eight_bit_mode, from ground to near full scale.
// - justify_select 0 right-aligns the code, 1 left-aligns it in the byte pair.
// - result bits not holding code bits read as zero.
// - result bytes are loaded with the new code when a conversion finishes.
// - eight_bit_mode resolves eight MSBs into the high byte, ignoring justify_select.
// - an 8-bit conversion takes two fewer conversion-clock ticks than 10-bit.
// - conversion clock is the system clock divided by conv_clock_divider plus one.
// - start_mode_select picks one of six triggers: software, timers 0/2/1, pin, timer 3.
// - in software mode, writing 1 to conversion_busy starts a conversion.
// - conversion_busy stays 1 for the whole conversion and clears when it completes.
// - busy falling at the end of a completed conversion sets conversion_done_flag and, if enabled, requests an interrupt.
// - timers 2 and 3 trigger by low-byte overflow in 8-bit, high-byte in 16-bit.
// - in external mode each rising edge of ext_start_pin starts a conversion.
// - delayed tracking postpones conversion start by three ticks while tracking.
// - without delayed tracking the conversion begins at once on its trigger.
// - with internal triggers the input is tracked whenever no conversion runs.
// - with pin trigger, track if delayed tracking, or if not and the pin is low.
// - in 8-bit mode the low result byte reads all zeros.

module sacc_top #(
   parameter int ADDR_W = 8
) (
   input wire logic clk, // system clock, 10 MHz
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire sacc_pkg::sacc_trig_t trig, // timer overflow pulses, same clock
   input wire logic ext_start_pin, // external start pin, asynchronous
   input wire logic cmp_in, // comparator: 1 when input at or above trial level
   output logic sar_powerdown, // analog shutdown request
   output logic sar_track, // 1 tracks the input, 0 holds it
   output logic [9:0] sar_dac, // trial code to the capacitor array
   output logic irq // interrupt request level
);
   import sacc_pkg::*;

   // ************************************************************
   // functions
   // ************************************************************

   // one-hot mask of a code bit
   function automatic logic [9:0] bit_mask(input logic [3:0] idx);
      logic [9:0] m;
      m = 10'h000;
      m[idx] = 1'b1;
      return m;
   endfunction

   // place a finished code into the high and low result bytes
   function automatic sacc_result_t format_result(input logic [9:0] code, input logic b8,
                                                  input logic ljst);
      sacc_result_t r;
      r.hi = code[9:2];
      r.lo = 8'h00;
      if (!b8 && !ljst) begin
         r.hi = {6'h00, code[9:8]};
         r.lo = code[7:0];
      end else if (!b8) begin
         r.lo = {code[1:0], 6'h00};
      end
      return r;
   endfunction

   // ************************************************************
   // reset release
   // ************************************************************

   logic rst_s1_r, rst_sync_b;

   // release is synchronised so that no flop leaves reset on a partial edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_sync_b <= rst_s1_r;
      end
   end

   // ************************************************************
   // declarations
   // ************************************************************

   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_byte_r;
   logic w_lane0_r;
   logic en_r, dtrack_r, done_r, busy_r, ie_r;
   logic [2:0] mode_r;
   logic [4:0] div_r;
   logic ljst_r, b8_r, gain_r;
   sacc_result_t res_r;
   sacc_state_t state_r;
   logic [4:0] div_cnt_r;
   logic [1:0] dly_cnt_r;
   logic [3:0] idx_r;
   logic [9:0] code_r;
   logic track_r, pd_r, irq_r;
   logic ext_s1_r, ext_s2_r, ext_s3_r;

   // ************************************************************
   // bus decode
   // ************************************************************

   // write performs once both address and data are held and no response is pending
   wire do_write = !awready_r && !wready_r && !bvalid_r;
   wire wr_lane0 = do_write && w_lane0_r;
   wire wr_ctrl = wr_lane0 && (aw_addr_r == ADDR_W'(`SACC_OFF_CTRL));
   wire wr_cfg = wr_lane0 && (aw_addr_r == ADDR_W'(`SACC_OFF_CFG));
   wire wr_ie = wr_lane0 && (aw_addr_r == ADDR_W'(`SACC_OFF_IRQ_EN));
   wire aw_map = aw_addr_r inside {ADDR_W'(`SACC_OFF_CTRL), ADDR_W'(`SACC_OFF_CFG),
                 ADDR_W'(`SACC_OFF_RES_HI), ADDR_W'(`SACC_OFF_RES_LO), ADDR_W'(`SACC_OFF_IRQ_EN)};
   wire ar_take = s_axi_arvalid && arready_r;

   // read data; the window flag position of the control byte reads zero
   wire [7:0] ctrl_rd = {en_r, dtrack_r, done_r, busy_r, 1'b0, mode_r};
   wire [7:0] cfg_rd = {div_r, ljst_r, b8_r, gain_r};
   wire rd_ctrl = s_axi_araddr == ADDR_W'(`SACC_OFF_CTRL);
   wire rd_cfg = s_axi_araddr == ADDR_W'(`SACC_OFF_CFG);
   wire rd_hi = s_axi_araddr == ADDR_W'(`SACC_OFF_RES_HI);
   wire rd_lo = s_axi_araddr == ADDR_W'(`SACC_OFF_RES_LO);
   wire rd_ie = s_axi_araddr == ADDR_W'(`SACC_OFF_IRQ_EN);
   wire rd_map = rd_ctrl || rd_cfg || rd_hi || rd_lo || rd_ie;
   wire [7:0] rd_byte = rd_ctrl ? ctrl_rd : rd_cfg ? cfg_rd : rd_hi ? res_r.hi :
                        rd_lo ? res_r.lo : rd_ie ? {7'h00, ie_r} : 8'h00;

   // ************************************************************
   // trigger selection
   // ************************************************************

   wire t2_ovf = trig.t2_16bit ? trig.t2_hi_ovf : trig.t2_lo_ovf;
   wire t3_ovf = trig.t3_16bit ? trig.t3_hi_ovf : trig.t3_lo_ovf;
   wire ext_rise = ext_s2_r && !ext_s3_r;
   wire sw_start = wr_ctrl && w_byte_r[`SACC_CTRL_BUSY_BIT];
   wire ext_mode = mode_r == SACC_MODE_EXT;
   // reserved codes select no source at all
   wire trig_hit = (mode_r == SACC_MODE_SW) ? sw_start :
                   (mode_r == SACC_MODE_T0) ? trig.t0_ovf :
                   (mode_r == SACC_MODE_T2) ? t2_ovf :
                   (mode_r == SACC_MODE_T1) ? trig.t1_ovf :
                   ext_mode ? ext_rise :
                   (mode_r == SACC_MODE_T3) ? t3_ovf : 1'b0;
   // only an idle, enabled converter accepts a start
   wire start = en_r && trig_hit && (state_r == SACC_ST_IDLE);

   // ************************************************************
   // sequencer next values
   // ************************************************************

   wire tick = div_cnt_r == div_r;
   wire [3:0] last_idx = b8_r ? `SACC_LAST_IDX_8B : `SACC_LAST_IDX_10B;
   wire conv_tick = (state_r == SACC_ST_CONV) && tick;
   wire finish = en_r && conv_tick && (idx_r == last_idx);
   wire dly_end = (state_r == SACC_ST_DELAY) && tick && (dly_cnt_r == `SACC_DELAY_TICKS - 2'h1);
   wire conv_go = (start && !dtrack_r) || dly_end;
   // a low comparator means the trial bit overshot and is dropped
   wire [9:0] code_kept = cmp_in ? code_r : (code_r & ~bit_mask(idx_r));
   wire [9:0] code_step = code_kept | bit_mask(idx_r - 4'h1);
   wire sacc_result_t res_new = format_result(code_kept, b8_r, ljst_r);
   wire done_nxt = finish || (done_r && !(wr_ctrl && !w_byte_r[`SACC_CTRL_DONE_BIT]));
   wire en_nxt = wr_ctrl ? w_byte_r[`SACC_CTRL_EN_BIT] : en_r;
   wire dtrack_nxt = wr_ctrl ? w_byte_r[`SACC_CTRL_DTRACK_BIT] : dtrack_r;
   wire idle_nxt = !en_r || finish || (state_r == SACC_ST_IDLE && !start);
   // pin-triggered without delay holds while the pin is high
   wire track_nxt = en_nxt && ((idle_nxt && (!ext_mode || dtrack_nxt || !ext_s2_r))
                    || (state_r == SACC_ST_DELAY && !dly_end) || (start && dtrack_r));

   // ************************************************************
   // AXI4-Lite handshakes
   // ************************************************************

   // address and data are taken independently, in either order
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= `SACC_AXI_OKAY;
         aw_addr_r <= '0;
         w_byte_r <= 8'h00;
         w_lane0_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
         end
         if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= aw_map ? `SACC_AXI_OKAY : `SACC_AXI_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // reads answer one cycle after the address is taken
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `SACC_AXI_OKAY;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rd_byte};
         rresp_r <= rd_map ? `SACC_AXI_OKAY : `SACC_AXI_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ************************************************************
   // software registers
   // ************************************************************

   // result bytes are read-only; writes to them are answered and dropped
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         {en_r, dtrack_r, done_r} <= 3'(`SACC_CTRL_RST >> `SACC_CTRL_DONE_BIT);
         mode_r <= 3'(`SACC_CTRL_RST);
         ie_r <= 1'b0;
         {div_r, ljst_r, b8_r, gain_r} <= `SACC_CFG_RST;
      end else begin
         en_r <= en_nxt;
         dtrack_r <= dtrack_nxt;
         done_r <= done_nxt;
         if (wr_ctrl) begin
            mode_r <= w_byte_r[`SACC_CTRL_MODE_MSB:`SACC_CTRL_MODE_LSB];
         end
         if (wr_ie) begin
            ie_r <= w_byte_r[0];
         end
         if (wr_cfg) begin
            {div_r, ljst_r, b8_r, gain_r} <= w_byte_r;
         end
      end
   end

   // ************************************************************
   // external start pin synchroniser
   // ************************************************************

   // the third stage only serves the edge detector, which never reads the first
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         {ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
      end else begin
         {ext_s1_r, ext_s2_r, ext_s3_r} <= {ext_start_pin, ext_s1_r, ext_s2_r};
      end
   end

   // ************************************************************
   // conversion clock divider
   // ************************************************************

   // restarting on a start aligns the first tick to a full divided period
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         div_cnt_r <= 5'h00;
      end else if (start || tick || !en_r) begin
         div_cnt_r <= 5'h00;
      end else begin
         div_cnt_r <= div_cnt_r + 5'h01;
      end
   end

   // ************************************************************
   // conversion sequencer
   // ************************************************************

   // disabling mid-conversion aborts it without touching results or the done flag
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_r <= SACC_ST_IDLE;
         busy_r <= 1'b0;
         dly_cnt_r <= 2'h0;
         idx_r <= 4'h0;
         code_r <= 10'h000;
         res_r <= 16'h0000;
      end else if (!en_r) begin
         state_r <= SACC_ST_IDLE;
         busy_r <= 1'b0;
      end else if (conv_go) begin
         state_r <= SACC_ST_CONV;
         busy_r <= 1'b1;
         idx_r <= `SACC_CODE_MSB_IDX;
         code_r <= bit_mask(`SACC_CODE_MSB_IDX);
      end else if (start) begin
         state_r <= SACC_ST_DELAY;
         busy_r <= 1'b1;
         dly_cnt_r <= 2'h0;
      end else if (state_r == SACC_ST_DELAY && tick) begin
         dly_cnt_r <= dly_cnt_r + 2'h1;
      end else if (finish) begin
         state_r <= SACC_ST_IDLE;
         busy_r <= 1'b0;
         code_r <= code_kept;
         res_r <= res_new;
      end else if (conv_tick) begin
         idx_r <= idx_r - 4'h1;
         code_r <= code_step;
      end
   end

   // ************************************************************
   // analog control and interrupt
   // ************************************************************

   // interrupt is a level that follows the done flag while enabled
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         track_r <= 1'b0;
         pd_r <= 1'b1;
         irq_r <= 1'b0;
      end else begin
         track_r <= track_nxt;
         pd_r <= !en_nxt;
         irq_r <= done_nxt && (wr_ie ? w_byte_r[0] : ie_r);
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign sar_powerdown = pd_r;
   assign sar_track = track_r;
   assign sar_dac = code_r;
   assign irq = irq_r;
endmodule

// ### sacc_ana_model.sv
// behavioural front end: sampling capacitor and comparator
`timescale 1ns/1ps
module sacc_ana_model (
   input wire logic clk, // system clock
   input wire logic sar_track, // 1 tracks the input
   input wire logic sar_powerdown, // analog shutdown request
   input wire logic [9:0] sar_dac, // trial code
   input wire logic [9:0] vin, // input level as a code
   output logic cmp_in // 1 when held input at or above trial
);
   logic [9:0] held = '0;
   logic junk = 1'b0;
   // the capacitor follows the input only while tracking
   always @(posedge clk) begin
      if (sar_track) held <= vin;
      junk <= ~junk;
   end
   // a shut-down comparator gives no useful answer, so it toggles
   assign cmp_in = sar_powerdown ? junk : (held >= sar_dac);
endmodule

// ### sacc_checker.sv
// concurrent checks of bus handshakes and hold phases at the top ports
`timescale 1ns/1ps
module sacc_checker (
   input wire logic clk, // system clock
   input wire logic rst_b, // reset, active low
   input wire logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address ready
   input wire logic s_axi_wvalid, // write data valid
   input wire logic s_axi_wready, // write data ready
   input wire logic s_axi_bvalid, // write response valid
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bready, // write response ready
   input wire logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic s_axi_rvalid, // read data valid
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic s_axi_rready, // read data ready
   input wire logic sar_track, // track or hold
   input wire logic sar_powerdown // analog shutdown
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ****
   // bus timing
   // ****
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wans;
      (!s_axi_awready && !s_axi_bvalid) ##1 s_axi_bvalid;
   endsequence
   property p_wr;
      s_wtake |=> s_wans;
   endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write not retired");
   property p_rhi;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
   endproperty
   a_rhi: assert property (p_rhi) else $error("read data upper bits set");
   property p_busy_ready;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy_ready: assert property (p_busy_ready) else $error("second write accepted");
   // ****
   // conversion hold phase
   // ****
   property p_hold_ends;
      $fell(sar_track) |-> ##[1:1000] (sar_track || sar_powerdown);
   endproperty
   a_hold_ends: assert property (p_hold_ends) else $error("hold never ends");
endmodule
bind sacc_top sacc_checker u_chk (.clk(clk), .rst_b(rst_b),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .s_axi_rready(s_axi_rready), .sar_track(sar_track), .sar_powerdown(sar_powerdown));

// ### testbench.sv
// self-checking bench of the conversion control block
`timescale 1ns/1ps
module testbench;
   import sacc_pkg::*;
   logic clk = 0, rst_b = 0, mon = 0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ext = 0;
   logic awready, wready, bvalid, arready, rvalid, cmp, pd, track, irq;
   logic [1:0] bresp, rresp, resp;
   logic [9:0] dac, vin = '0;
   sacc_trig_t trig = '0;
   int n_fail = 0, checked = 0, lo_cnt = 0, pre_cnt = 0;
   sacc_top dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trig(trig), .ext_start_pin(ext), .cmp_in(cmp), .sar_powerdown(pd), .sar_track(track),
      .sar_dac(dac), .irq(irq));
   sacc_ana_model ana (.clk(clk), .sar_track(track), .sar_powerdown(pd), .sar_dac(dac),
      .vin(vin), .cmp_in(cmp));
   initial begin
      forever #50 clk = ~clk;
   end
   // lead-in and hold lengths tell conversion lengths apart without seeing the sequencer
   always @(posedge clk) begin
      if (!mon) begin
         lo_cnt <= 0;
         pre_cnt <= 0;
      end else if (!track) begin
         lo_cnt <= lo_cnt + 1;
      end else if (lo_cnt == 0) begin
         pre_cnt <= pre_cnt + 1;
      end
   end
   // ****
   // bus and compare tasks
   // ****
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      fork
         begin
            do @(posedge clk); while (!awready);
            awvalid <= 0;
         end
         begin
            do @(posedge clk); while (!wready);
            wvalid <= 0;
         end
      join
      do @(posedge clk); while (!bvalid);
      resp = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      do @(posedge clk); while (!rvalid);
      d = rdata[7:0];
      resp = rresp;
      rready <= 0;
   endtask
   task automatic conv(input logic [7:0] cfg, input logic dt, input logic [9:0] c,
         input logic rt, output int lo, output int pre);
      logic [7:0] d, h, l;
      logic [15:0] e;
      vin <= c;
      wr(8'h04, cfg);
      wr(8'h00, {1'b1, dt, 6'h00});
      mon <= 1;
      wr(8'h00, {1'b1, dt, 6'h10});
      if (rt) wr(8'h00, {1'b1, dt, 6'h10});
      d = 8'h00;
      for (int i = 0; i < 200 && !d[5]; i++) rd(8'h00, d);
      chk("ctrl", {8'h00, d & 8'h30}, 16'h0020);
      rd(8'h08, h);
      rd(8'h0C, l);
      e = cfg[1] ? {c[9:2], 8'h00} : cfg[2] ? {c, 6'h00} : {6'h00, c};
      chk("result", {h, l}, e);
      lo = lo_cnt;
      pre = pre_cnt;
      mon <= 0;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_rst;
      logic [7:0] d;
      chk("pdown", 16'(pd), 16'h1);
      rd(8'h04, d);
      chk("cfg", 16'(d), 16'h00F9);
      rd(8'h00, d);
      chk("ctrl", 16'(d), 16'h0);
      wr(8'h08, 8'h55);
      chk("wresp", 16'(resp), 16'h0);
      rd(8'h08, d);
      chk("res_hi", 16'(d), 16'h0);
      rd(8'h14, d);
      chk("unmapped", 16'(resp), 16'h2);
      wr(8'h00, 8'h80);
      repeat (3) @(posedge clk);
      chk("pdown", 16'(pd), 16'h0);
   endtask
   task automatic t_fmt;
      logic [7:0] cf[5] = '{8'h01, 8'h05, 8'h05, 8'h03, 8'h07};
      logic [9:0] cd[5] = '{10'h3FF, 10'h3FF, 10'h2A5, 10'h2A5, 10'h000};
      int x, y;
      foreach (cf[i]) conv(cf[i], 0, cd[i], 0, x, y);
      chk("irq", 16'(irq), 16'h0);
   endtask
   task automatic t_time;
      int a, b, c, p0, p1, x, y;
      conv(8'h11, 0, 10'h155, 0, a, p0);
      conv(8'h13, 0, 10'h155, 0, b, x);
      chk("len8", 16'(a - b), 16'd6);
      conv(8'h01, 0, 10'h155, 0, c, x);
      chk("lendiv", 16'(a - c), 16'd20);
      conv(8'h11, 1, 10'h155, 0, y, p1);
      chk("delay", 16'(p1 - p0), 16'd9);
      chk("hold", 16'(y), 16'(a));
      conv(8'hF9, 0, 10'h2AA, 0, x, c);
      conv(8'hF9, 0, 10'h2AA, 1, y, c);
      chk("retrig", 16'(y), 16'(x));
   endtask
   task automatic t_irq;
      int x, y;
      wr(8'h10, 8'h01);
      conv(8'h01, 0, 10'h0F0, 0, x, y);
      chk("irq", 16'(irq), 16'h1);
      wr(8'h00, 8'h80);
      repeat (2) @(posedge clk);
      chk("irq", 16'(irq), 16'h0);
      wr(8'h10, 8'h00);
   endtask
   // timer levels stay put while every other overflow is tried before the chosen one
   task automatic t_trig;
      logic [2:0] md[7] = '{3'h1, 3'h3, 3'h2, 3'h2, 3'h5, 3'h5, 3'h4};
      logic [7:0] lv[7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00};
      logic [7:0] rg[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h00};
      logic [7:0] d;
      wr(8'h04, 8'h01);
      foreach (md[i]) begin
         wr(8'h00, {5'h10, md[i]});
         trig <= sacc_trig_t'(lv[i] | (8'hF6 & ~rg[i]));
         @(posedge clk);
         trig <= sacc_trig_t'(lv[i]);
         repeat (30) @(posedge clk);
         rd(8'h00, d);
         chk("idle", 16'(d[5:4]), 16'h0);
         if (md[i] == 3'h4) ext <= 1;
         else trig <= sacc_trig_t'(lv[i] | rg[i]);
         @(posedge clk);
         trig <= sacc_trig_t'(lv[i]);
         repeat (8) @(posedge clk);
         ext <= 0;
         for (int k = 0; k < 100 && !d[5]; k++) rd(8'h00, d);
         chk("start", 16'(d[5:4]), 16'h2);
      end
      trig <= '0;
      wr(8'h00, 8'h86);
      wr(8'h00, 8'h96);
      repeat (30) @(posedge clk);
      rd(8'h00, d);
      chk("reserved", 16'(d), 16'h0086);
   endtask
   task automatic t_off;
      logic [7:0] d;
      wr(8'h04, 8'hF9);
      wr(8'h00, 8'h80);
      wr(8'h00, 8'h90);
      wr(8'h00, 8'h00);
      rd(8'h00, d);
      chk("abort", 16'(d), 16'h0);
      chk("pdown", 16'(pd), 16'h1);
   endtask
   task automatic conclude;
      $display("checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      t_rst;
      $display("reset test done");
      t_fmt;
      $display("format test done");
      t_time;
      $display("timing test done");
      t_irq;
      $display("interrupt test done");
      t_trig;
      $display("trigger test done");
      t_off;
      $display("shutdown test done");
      conclude;
   end
   // watchdog, far beyond the few thousand cycles the tests need
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      conclude;
   end
endmodule
